// ==== design/lra_open_loop_drive_config.sv ====
// Configuration and status registers with fallback tracking for open-loop actuator drive
`timescale 1ns/1ps
module lra_open_loop_drive_config
  import lra_drive_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire reg_access_type regAccess,
  output logic [7:0] readData,
  output logic readValid,
  input wire logic playbackActive,
  input wire logic openLoopRequest,
  input wire logic zeroCrossingEvent,
  input wire logic zeroCrossingMiss,
  input wire logic impedanceCoefLoad,
  input wire logic [7:0] impedanceCoefValue,
  output drive_out_type driveOut
);

  // Register map, one byte per address:
  //   fallback and shape control: enable bit 7, attempt code 6:5, reserved 4:1, shape 0
  //   period high: reserved 7:2, period bits 9:8
  //   period low: period bits 7:0
  //   impedance coefficient: read only, loaded by the diagnostic run
  // Anything outside these addresses reads as zero and ignores writes.
  // Writes to the coefficient address are dropped, so a diagnostic load always wins.
  // The period halves land independently with no shadow copy, so a running
  // generator may see a half-updated code for one period; write both halves
  // while open-loop drive is idle.

  // Whole state of the register bank
  typedef struct packed {
    // Host-visible register fields
    logic autoFallbackEnable;
    logic [1:0] fallbackAttemptCount;
    logic [3:0] ctrlReserved;
    logic driveShapeSelect;
    logic [5:0] periodHighReserved;
    logic [9:0] fixedDrivePeriod;
    logic [7:0] impedanceCoef;
    // Internal tracking and read port
    logic [2:0] missCount;
    track_state_type track;
    logic [7:0] readData;
    logic readValid;
    // Shape actually applied to the drive
    logic driveSine;
  } bank_state_type;

  // Registered state and its next value
  bank_state_type state;
  bank_state_type next_state;
  logic openLoopActive; // Open-loop drive in effect
  logic genPolarity; // Generator outputs
  logic genStrobe;
  logic [9:0] genStep;

  // Miss threshold from the two-bit attempt code
  // Codes 0 to 3 give 3 to 6 consecutive misses
  function automatic logic [2:0] attempt_limit(input logic [1:0] code);
    attempt_limit = ATTEMPT_BASE + {1'b0, code};
  endfunction : attempt_limit

  // Read mux for one register
  // Unmapped addresses read as zero; reserved bits read back as written
  function automatic logic [7:0] read_mux(input bank_state_type s, input logic [7:0] addr);
    case (addr)
      OFFSET_FALLBACK_SHAPE_CTRL: read_mux = {s.autoFallbackEnable, s.fallbackAttemptCount,
                                              s.ctrlReserved, s.driveShapeSelect};
      OFFSET_PERIOD_HIGH: read_mux = {s.periodHighReserved, s.fixedDrivePeriod[9:8]};
      OFFSET_PERIOD_LOW: read_mux = s.fixedDrivePeriod[7:0];
      OFFSET_IMPEDANCE_COEF: read_mux = s.impedanceCoef;
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // Open loop runs on request or after a fallback
  assign openLoopActive = openLoopRequest || (state.track == TRACK_FALLBACK);

  // Within one cycle a crossing, idle playback or a disabled fallback clears
  // the miss tally ahead of any miss, so a crossing beats a simultaneous miss.
  // Software open loop suspends counting; only the automatic path forces the
  // square shape, software open loop keeps the selected one.
  // Register writes, read answers, fallback tracking
  always_comb begin
    next_state = state;
    next_state.readValid = 1'b0;

    // Register writes
    if (regAccess.writeEn) begin
      case (regAccess.addr)
        // Control fields
        OFFSET_FALLBACK_SHAPE_CTRL: begin
          next_state.autoFallbackEnable = regAccess.writeData[POS_AUTO_FALLBACK_ENABLE];
          next_state.fallbackAttemptCount = regAccess.writeData[POS_ATTEMPT_COUNT_LSB +: 2];
          next_state.ctrlReserved = regAccess.writeData[POS_RESERVED_CTRL_LSB +: 4];
          next_state.driveShapeSelect = regAccess.writeData[POS_DRIVE_SHAPE_SELECT];
        end
        // Reserved bits and period bits 9:8
        OFFSET_PERIOD_HIGH: begin
          next_state.periodHighReserved = regAccess.writeData[7:2];
          next_state.fixedDrivePeriod[9:8] = regAccess.writeData[1:0];
        end
        // Period bits 7:0
        OFFSET_PERIOD_LOW: begin
          next_state.fixedDrivePeriod[7:0] = regAccess.writeData;
        end
        default: begin
          // Coefficient is read-only, other addresses ignore writes
        end
      endcase
    end

    // Diagnostic run deposits its coefficient
    if (impedanceCoefLoad) begin
      next_state.impedanceCoef = impedanceCoefValue;
    end

    // Read answer, one cycle after the strobe
    // With both strobes in one cycle the read returns the value before the write
    if (regAccess.readEn) begin
      next_state.readData = read_mux(state, regAccess.addr);
      next_state.readValid = 1'b1;
    end

    // Fallback tracker
    case (state.track)
      TRACK_ARMED: begin
        // Closed loop tracking counts consecutive misses
        if (!playbackActive || !state.autoFallbackEnable || zeroCrossingEvent) begin
          // Good crossing or idle clears the miss tally; disabled means no fallback
          next_state.missCount = '0;
        end else if (zeroCrossingMiss && !openLoopRequest) begin
          // The miss that reaches the limit switches to open loop
          if (state.missCount + 3'h1 >= attempt_limit(state.fallbackAttemptCount)) begin
            next_state.track = TRACK_FALLBACK;
            next_state.missCount = '0;
          end else begin
            next_state.missCount = state.missCount + 3'h1;
          end
        end
      end
      TRACK_FALLBACK: begin
        // Hold open loop until the waveform ends
        if (!playbackActive) begin
          next_state.track = TRACK_ARMED;
        end
      end
      default: begin
        // Unused encoding returns to closed loop
        next_state.track = TRACK_ARMED;
      end
    endcase

    // Effective shape: fallback forces square
    // Taken from the next state so shape and mode change in the same cycle
    if (next_state.track == TRACK_FALLBACK) begin
      next_state.driveSine = 1'b0;
    end else begin
      next_state.driveSine = next_state.driveShapeSelect;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      // Register fields to their values after reset, tracker re-armed
      state.autoFallbackEnable <= RESET_FALLBACK_SHAPE_CTRL[POS_AUTO_FALLBACK_ENABLE];
      state.fallbackAttemptCount <= RESET_FALLBACK_SHAPE_CTRL[POS_ATTEMPT_COUNT_LSB +: 2];
      state.ctrlReserved <= RESET_FALLBACK_SHAPE_CTRL[POS_RESERVED_CTRL_LSB +: 4];
      state.driveShapeSelect <= RESET_FALLBACK_SHAPE_CTRL[POS_DRIVE_SHAPE_SELECT];
      state.periodHighReserved <= RESET_PERIOD_HIGH[7:2];
      state.fixedDrivePeriod <= {RESET_PERIOD_HIGH[1:0], RESET_PERIOD_LOW};
      state.impedanceCoef <= RESET_IMPEDANCE_COEF;
      state.missCount <= '0;
      state.track <= TRACK_ARMED;
      // Read port idle, square shape
      state.readData <= 8'h00;
      state.readValid <= 1'b0;
      state.driveSine <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Period generator, runs only while open-loop drive plays
  // It restarts from step zero whenever run drops, so each playback
  // begins on a fresh period with polarity low
  open_loop_period_gen #(
    .PERIOD_WIDTH(10)
  ) u_period_gen (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(openLoopActive && playbackActive),
    .periodCode(state.fixedDrivePeriod),
    .drivePolarity(genPolarity),
    .periodStrobe(genStrobe),
    .stepIndex(genStep)
  );

  // Outputs
  // Read port
  assign readData = state.readData;
  assign readValid = state.readValid;
  // Drive decision; the open-loop flag follows the request without delay
  assign driveOut.openLoopActive = openLoopActive;
  assign driveOut.fallbackActive = (state.track == TRACK_FALLBACK);
  assign driveOut.driveSine = state.driveSine;
  assign driveOut.drivePolarity = genPolarity;
  assign driveOut.periodStrobe = genStrobe;
  assign driveOut.stepIndex = genStep;

endmodule : lra_open_loop_drive_config

// ==== design/lra_drive_pkg.sv ====
// Shared constants and types for the open-loop actuator drive register bank
package lra_drive_pkg;

  // Register offsets
  localparam logic [7:0] OFFSET_FALLBACK_SHAPE_CTRL = 8'h2c;
  localparam logic [7:0] OFFSET_PERIOD_HIGH = 8'h2e;
  localparam logic [7:0] OFFSET_PERIOD_LOW = 8'h2f;
  localparam logic [7:0] OFFSET_IMPEDANCE_COEF = 8'h30;

  // Field positions in the fallback and shape control register
  localparam int POS_AUTO_FALLBACK_ENABLE = 7;
  localparam int POS_ATTEMPT_COUNT_LSB = 5;
  localparam int POS_RESERVED_CTRL_LSB = 1;
  localparam int POS_DRIVE_SHAPE_SELECT = 0;

  // Values after reset
  localparam logic [7:0] RESET_FALLBACK_SHAPE_CTRL = 8'h00;
  localparam logic [7:0] RESET_PERIOD_HIGH = 8'h00;
  localparam logic [7:0] RESET_PERIOD_LOW = 8'hc6;
  localparam logic [7:0] RESET_IMPEDANCE_COEF = 8'h00;

  // Attempt count code 0 means this many missed attempts
  localparam logic [2:0] ATTEMPT_BASE = 3'h3;

  // Unit step of the drive period, in picoseconds, and clock period
  localparam int UNIT_STEP_PS = 24615000;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int STEP_CYCLES = (UNIT_STEP_PS / CLK_PERIOD_PS < 1) ? 1 : UNIT_STEP_PS / CLK_PERIOD_PS;

  // Register access strobe from the serial interface engine
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] writeData;
    logic writeEn;
    logic readEn;
  } reg_access_type;

  // Drive decision towards the output stage
  typedef struct packed {
    logic openLoopActive;
    logic fallbackActive;
    logic driveSine;
    logic drivePolarity;
    logic periodStrobe;
    logic [9:0] stepIndex;
  } drive_out_type;

  // Fallback tracker states
  typedef enum logic [0:0] {
    TRACK_ARMED = 1'b0,
    TRACK_FALLBACK = 1'b1
  } track_state_type;

endpackage : lra_drive_pkg

// ==== design/open_loop_period_gen.sv ====
// Open-loop period generator stepping in unit steps of the drive period
`timescale 1ns/1ps
module open_loop_period_gen
  import lra_drive_pkg::*;
#(
  parameter int PERIOD_WIDTH = 10
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic run,
  input wire logic [PERIOD_WIDTH-1:0] periodCode,
  output logic drivePolarity,
  output logic periodStrobe,
  output logic [PERIOD_WIDTH-1:0] stepIndex
);

  // Whole state of the generator
  typedef struct packed {
    logic [11:0] stepDiv;
    logic [PERIOD_WIDTH-1:0] stepCount;
    logic polarity;
    logic strobe;
  } gen_state_type;

  gen_state_type state;
  gen_state_type next_state;
  logic [PERIOD_WIDTH-1:0] halfCode; // Step at which the polarity flips mid-period

  assign halfCode = periodCode >> 1;

  // Divide clock into unit steps, count steps, flip polarity each half period
  always_comb begin
    next_state = state;
    next_state.strobe = 1'b0;
    if (!run || periodCode == '0) begin
      // Stopped, or a zero period which cannot be driven
      next_state = '0;
    end else if (state.stepDiv == 12'(STEP_CYCLES - 1)) begin
      next_state.stepDiv = '0;
      if (state.stepCount == periodCode - 1'b1) begin
        // Period complete
        next_state.stepCount = '0;
        next_state.polarity = ~state.polarity;
        next_state.strobe = 1'b1;
      end else begin
        next_state.stepCount = state.stepCount + 1'b1;
        // Mid-period flip, skipped for a one-step period
        if (halfCode != '0 && state.stepCount == halfCode - 1'b1) begin
          next_state.polarity = ~state.polarity;
        end
      end
    end else begin
      next_state.stepDiv = state.stepDiv + 12'h001;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign drivePolarity = state.polarity;
  assign periodStrobe = state.strobe;
  assign stepIndex = state.stepCount;

endmodule : open_loop_period_gen

// ==== tb/lra_open_loop_drive_config_props.sv ====
// Port-level checker for the actuator drive register bank
`timescale 1ns/1ps
module lra_open_loop_drive_config_props
  import lra_drive_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire reg_access_type regAccess,
  input wire logic [7:0] readData,
  input wire logic readValid,
  input wire logic playbackActive,
  input wire logic openLoopRequest,
  input wire logic zeroCrossingEvent,
  input wire logic zeroCrossingMiss,
  input wire logic impedanceCoefLoad,
  input wire logic [7:0] impedanceCoefValue,
  input wire drive_out_type driveOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Register reads answer one cycle later, only when asked
  a_read_answer: assert property (regAccess.readEn |=> readValid) else $error("read not answered");
  a_read_cause: assert property (!regAccess.readEn |=> !readValid) else $error("answer without read");
  a_coef_read: assert property (impedanceCoefLoad ##1 (regAccess.readEn && !impedanceCoefLoad
    && regAccess.addr == OFFSET_IMPEDANCE_COEF) |=> readData == $past(impedanceCoefValue, 2))
    else $error("coefficient read wrong");
  // Fallback drive is square and counts as open loop
  a_fallback_square: assert property (driveOut.fallbackActive |-> !driveOut.driveSine)
    else $error("sine during fallback");
  a_open_loop_sum: assert property (driveOut.openLoopActive == (openLoopRequest | driveOut.fallbackActive))
    else $error("open loop flag wrong");
  a_fallback_cause: assert property ($rose(driveOut.fallbackActive) |-> $past(zeroCrossingMiss)
    && $past(playbackActive) && !$past(zeroCrossingEvent) && !$past(openLoopRequest))
    else $error("fallback without miss");
  // Fallback holds through playback and re-arms after it
  a_fallback_hold: assert property (driveOut.fallbackActive && playbackActive |=> driveOut.fallbackActive)
    else $error("fallback dropped early");
  a_fallback_rearm: assert property (driveOut.fallbackActive && !playbackActive |=> !driveOut.fallbackActive)
    else $error("fallback not re-armed");
  a_strobe_single: assert property (driveOut.periodStrobe |=> !driveOut.periodStrobe)
    else $error("period strobe too long");
endmodule : lra_open_loop_drive_config_props
bind lra_open_loop_drive_config lra_open_loop_drive_config_props props_inst (.clk_sys(clk_sys), .reset(reset),
  .regAccess(regAccess), .readData(readData), .readValid(readValid), .playbackActive(playbackActive),
  .openLoopRequest(openLoopRequest), .zeroCrossingEvent(zeroCrossingEvent), .zeroCrossingMiss(zeroCrossingMiss),
  .impedanceCoefLoad(impedanceCoefLoad), .impedanceCoefValue(impedanceCoefValue), .driveOut(driveOut));

// ==== tb/lra_model.sv ====
// Behavioural actuator giving one zero crossing verdict per attempt
`timescale 1ns/1ps
module lra_model
  import lra_drive_pkg::*;
#(
  parameter int ATTEMPT_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire drive_out_type driveOut,
  input wire logic stalled,
  output logic zeroCrossingEvent = 1'b0,
  output logic zeroCrossingMiss = 1'b0
);
  // Cycles into the present attempt
  int tick = 0;
  // No tracking while driven open loop; a stalled actuator misses
  always @(posedge clk_sys) begin
    tick <= (tick + 1) % ATTEMPT_CYCLES;
    zeroCrossingEvent <= tick == 0 && !driveOut.openLoopActive && !stalled;
    zeroCrossingMiss <= tick == 0 && !driveOut.openLoopActive && stalled;
  end
endmodule : lra_model

// ==== tb/tb.sv ====
// Self-checking bench for the actuator drive register bank
`timescale 1ns/1ps
module tb
  import lra_drive_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  reg_access_type regAccess = '0;
  logic [7:0] readData;
  logic readValid;
  logic playbackActive = 1'b0;
  logic openLoopRequest = 1'b0;
  logic zeroCrossingEvent;
  logic zeroCrossingMiss;
  logic impedanceCoefLoad = 1'b0;
  logic [7:0] impedanceCoefValue = 8'h00;
  logic stalled = 1'b0;
  drive_out_type driveOut;
  int fails = 0;
  int compares = 0;
  always #5 clk_sys = ~clk_sys;
  lra_open_loop_drive_config lra_open_loop_drive_config_inst (.clk_sys(clk_sys), .reset(reset),
    .regAccess(regAccess), .readData(readData), .readValid(readValid), .playbackActive(playbackActive),
    .openLoopRequest(openLoopRequest), .zeroCrossingEvent(zeroCrossingEvent), .zeroCrossingMiss(zeroCrossingMiss),
    .impedanceCoefLoad(impedanceCoefLoad), .impedanceCoefValue(impedanceCoefValue), .driveOut(driveOut));
  lra_model lra_model_inst (.clk_sys(clk_sys), .driveOut(driveOut), .stalled(stalled),
    .zeroCrossingEvent(zeroCrossingEvent), .zeroCrossingMiss(zeroCrossingMiss));
  task stop_test;
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) regAccess <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys) regAccess.writeEn <= 1'b0;
  endtask : wr
  // Read strobe, then answer one cycle later
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys) regAccess <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys) regAccess.readEn <= 1'b0;
    #1;
    chk("readValid", readValid, 1'b1);
    chk("readData", readData, exp);
  endtask : rd
  task t_regs;
    rd(OFFSET_FALLBACK_SHAPE_CTRL, 8'h00);
    rd(OFFSET_PERIOD_HIGH, 8'h00);
    rd(OFFSET_PERIOD_LOW, 8'hc6);
    rd(8'h2d, 8'h00);
    wr(OFFSET_PERIOD_HIGH, 8'hfc);
    rd(OFFSET_PERIOD_HIGH, 8'hfc);
    wr(OFFSET_PERIOD_LOW, 8'h02);
    rd(OFFSET_PERIOD_LOW, 8'h02);
  endtask : t_regs
  // Diagnostic load is readable, host writes never land
  task t_coef;
    @(posedge clk_sys) begin
      impedanceCoefLoad <= 1'b1;
      impedanceCoefValue <= 8'h5a;
    end
    fork
      rd(OFFSET_IMPEDANCE_COEF, 8'h5a);
      @(posedge clk_sys) impedanceCoefLoad <= 1'b0;
    join
    wr(OFFSET_IMPEDANCE_COEF, 8'hff);
    rd(OFFSET_IMPEDANCE_COEF, 8'h5a);
  endtask : t_coef
  // Strobe spacing, polarity flips and step count for period code 2
  task t_period;
    int gap;
    int flips;
    logic pol;
    @(posedge clk_sys) begin
      openLoopRequest <= 1'b1;
      playbackActive <= 1'b1;
    end
    for (int k = 0; k < 2; k++) begin
      gap = 0;
      flips = 0;
      pol = driveOut.drivePolarity;
      do begin
        cyc(1);
        gap++;
        if (driveOut.drivePolarity !== pol) flips++;
        pol = driveOut.drivePolarity;
      end while (driveOut.periodStrobe !== 1'b1 && gap < 6 * STEP_CYCLES);
    end
    chk("period", 16'(gap), 16'(2 * STEP_CYCLES));
    chk("polarityFlips", 16'(flips), 16'h0002);
    chk("stepIndex", driveOut.stepIndex, 10'h000);
  endtask : t_period
  task t_shape;
    wr(OFFSET_FALLBACK_SHAPE_CTRL, 8'h01);
    cyc(2);
    chk("driveSine", driveOut.driveSine, 1'b1);
    wr(OFFSET_FALLBACK_SHAPE_CTRL, 8'h00);
    cyc(2);
    chk("driveSine", driveOut.driveSine, 1'b0);
    chk("openLoopActive", driveOut.openLoopActive, 1'b1);
    @(posedge clk_sys) begin
      openLoopRequest <= 1'b0;
      playbackActive <= 1'b0;
    end
  endtask : t_shape
  // Stalled actuator during playback, shape bit set to sine
  task t_fallback(input logic [1:0] code, input logic en);
    int n;
    int misses;
    logic prev;
    n = code + 3;
    misses = 0;
    prev = 1'b0;
    wr(OFFSET_FALLBACK_SHAPE_CTRL, {en, code, 5'h01});
    rd(OFFSET_FALLBACK_SHAPE_CTRL, {en, code, 5'h01});
    @(posedge clk_sys) begin
      playbackActive <= 1'b1;
      stalled <= 1'b1;
    end
    repeat (n * 4 + 12) begin
      @(posedge clk_sys) #1;
      if (prev) misses++;
      chk("fallbackActive", driveOut.fallbackActive, en && misses >= n);
      chk("openLoopActive", driveOut.openLoopActive, en && misses >= n);
      prev = zeroCrossingMiss;
    end
    if (en) chk("fallbackSine", driveOut.driveSine, 1'b0);
    @(posedge clk_sys) playbackActive <= 1'b0;
    stalled <= 1'b0;
    cyc(2);
    chk("rearm", driveOut.fallbackActive, 1'b0);
  endtask : t_fallback
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs;
    t_coef;
    t_period;
    t_shape;
    for (int c = 0; c < 4; c++) t_fallback(2'(c), 1'b1);
    t_fallback(2'h3, 1'b0);
    stop_test;
  end
  // Cut a hang short
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    stop_test;
  end
endmodule : tb
